// file: bench/dac_ctrl_tb.sv
`timescale 1ns/1ns
module dac_ctrl_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       ce = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic       avs_read = 1'b0;
    logic       avs_write = 1'b0;
    logic [7:0] avs_writedata = 8'h00;
    logic [7:0] avs_readdata;
    logic       avs_waitrequest;
    logic       power_stage_sync_r, power_stage_sync_two, amp_out_change;
    logic [9:0] adc_result;
    logic       other_conv_req = 1'b0;
    logic       amp_on, amp_shunt_sw, amp_gnd_sw, amp_neg_pin_sw;
    logic [1:0] amp_gain;
    logic       amp_sample, adc_sample, conv_busy, conv_done;
    logic       other_conv_grant;
    logic [7:0] q;
    int         n_mismatch = 0;
    int         total_checks = 0;
    int         busy_cnt = 0;
    int         samp_cnt = 0;
    int         grant_bad = 0;
    int         c;

    dac_ctrl    uut (.*);
    dac_partner far (.*);

    always #5 clk_sys = ~clk_sys;

    // Busy and sample lengths, and any grant while busy
    always @(posedge clk_sys) begin
        if (conv_busy === 1'b1) busy_cnt++;
        if (adc_sample === 1'b1) samp_cnt++;
        if (conv_busy === 1'b1 && other_conv_grant !== 1'b0) grant_bad++;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Holds the request until waitrequest is seen low, then one idle edge
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) n_mismatch++;
        @(posedge clk_sys);
    endtask : bus

    task rd(input logic [3:0] a, input string nm, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(nm, 10'(e), 10'(q));
    endtask : rd

    // Write control, then let the switch outputs follow
    task wctl(input logic [7:0] d);
        bus(1'b1, dac_pkg::ADDR_CTRL, d);
        repeat (2) @(posedge clk_sys);
    endtask : wctl

    task start(input logic [9:0] v, input logic [7:0] cmd);
        far.set_result(v);
        busy_cnt = 0;
        samp_cnt = 0;
        bus(1'b1, dac_pkg::ADDR_CONV, cmd);
    endtask : start

    task wait_done;
        int n;
        n = 0;
        while (conv_done !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 300) n_mismatch++;
        // Busy drops on this same edge; let the monitor count it first
        @(posedge clk_sys);
    endtask : wait_done

    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    // Whole run is well under a thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        other_conv_req <= 1'b1;
        @(posedge clk_sys);
        rd(dac_pkg::ADDR_CTRL, "ctrl_reset", 8'h00);
        chk("neg_pin_reset", 10'h001, 10'(amp_neg_pin_sw));
        wctl(8'hFF);
        rd(dac_pkg::ADDR_CTRL, "ctrl_mask", 8'hFB);
        chk("shunt_gnd", 10'h000, 10'(amp_gnd_sw));
        chk("shunt_on", 10'h001, 10'(amp_shunt_sw));
        for (int g = 0; g < 4; g++) begin
            wctl(8'h80 | 8'(g << 4));
            chk("gain", 10'(g), 10'(amp_gain));
        end
        wctl(8'h88);
        chk("gnd_on", 10'h001, 10'(amp_gnd_sw));
        chk("neg_pin_off", 10'h000, 10'(amp_neg_pin_sw));
        wctl(8'h80);
        chk("neg_pin_on", 10'h001, 10'(amp_neg_pin_sw));
        bus(1'b1, 4'h7, 8'hFF);
        rd(4'h7, "unmapped", 8'h00);
        // Park on the reserved code so source changes make no edge
        wctl(8'h82);
        repeat (10) @(posedge clk_sys);
        for (int s = 1; s < 4; s++) begin
            for (int l = 0; l < 2; l++) begin
                wctl(8'h80 | 8'(s));
                c = 0;
                fork
                    far.pulse(l[0]);
                    repeat (40) begin
                        @(posedge clk_sys);
                        if (amp_sample === 1'b1) c++;
                    end
                join
                chk("sync_evt", 10'((s == 1 && l == 0) || (s == 3 && l == 1)),
                    10'(c));
            end
        end
        wctl(8'h80);
        c = 0;
        repeat (64) begin
            @(posedge clk_sys);
            if (amp_sample === 1'b1) c++;
        end
        chk("div8_evt", 10'h008, 10'(c));
        start(10'h2A5, 8'h05);
        wait_done();
        chk("conv_len", 10'h001, 10'(busy_cnt == 13 || busy_cnt == 14));
        chk("sample_len", 10'(dac_pkg::SAMPLE_END), 10'(samp_cnt));
        repeat (2) @(posedge clk_sys);
        chk("grant_idle", 10'h001, 10'(other_conv_grant));
        rd(dac_pkg::ADDR_RES_LO, "res_lo", 8'hA5);
        rd(dac_pkg::ADDR_RES_HI, "res_hi", 8'h02);
        rd(dac_pkg::ADDR_RES_LO, "lock_lo", 8'hA5);
        start(10'h155, 8'h05);
        wait_done();
        rd(dac_pkg::ADDR_RES_HI, "lock_hi", 8'h02);
        start(10'h0F0, 8'h05);
        far.wobble(6);
        wait_done();
        chk("abort_len", 10'h001, 10'(busy_cnt > 14));
        start(10'h0F0, 8'h05);
        wctl(8'h00);
        chk("en_held", 10'h001, 10'(amp_on));
        wait_done();
        repeat (3) @(posedge clk_sys);
        chk("en_off", 10'h000, 10'(amp_on));
        wctl(8'h81);
        start(10'h3C3, 8'h07);
        repeat (20) @(posedge clk_sys);
        // Armed and waiting for the sync edge counts as busy
        chk("auto_wait", 10'h001, 10'(conv_busy));
        rd(dac_pkg::ADDR_STATUS, "auto_idle", 8'h00);
        fork
            far.pulse(1'b0);
            wait_done();
        join
        rd(dac_pkg::ADDR_RES_LO, "auto_lo", 8'hC3);
        chk("grant_busy", 10'h000, 10'(grant_bad));
        stop_test();
    end
endmodule : dac_ctrl_tb

// file: bench/dac_partner.sv
`timescale 1ns/1ns
// Far side: power stage sync outputs and the converter core levels
module dac_partner (
    // Clock
    input  wire logic       clk_sys,
    // Levels seen by the block
    output logic            power_stage_sync_r,
    output logic            power_stage_sync_two,
    output logic            amp_out_change,
    output logic      [9:0] adc_result
);
    initial begin
        power_stage_sync_r   = 1'b0;
        power_stage_sync_two = 1'b0;
        amp_out_change       = 1'b0;
        adc_result           = 10'h000;
    end

    // One sync event; 12 cycle period keeps it far below ADC clock/4
    task pulse(input logic two);
        if (two) power_stage_sync_two <= 1'b1;
        else power_stage_sync_r <= 1'b1;
        repeat (6) @(posedge clk_sys);
        power_stage_sync_r   <= 1'b0;
        power_stage_sync_two <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : pulse

    // Amplifier output moving for n cycles
    task wobble(input int n);
        amp_out_change <= 1'b1;
        repeat (n) @(posedge clk_sys);
        amp_out_change <= 1'b0;
    endtask : wobble

    task set_result(input logic [9:0] v);
        adc_result <= v;
    endtask : set_result
endmodule : dac_partner

// file: hdl/dac_ctrl.sv
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Contract
// - Sample on falling sync edge, independent of ADC
// - Div8 sync: 13 cycles low, 14 high
// - Start bit starts amplified conversion
// - Refuse other channel while converting
// - Abort on output change, restart when stable (code aborts only in the sample window; later changes hold the count)
// - Auto trigger: start at next sync event
// - Ground select frees negative pin, grounds input
// - Enable clear waits for conversion end
// - Shunt shorts inputs, releases ground switch
// - Two gain bits select 5/10/20/40
// - Sync select: div8, sync R, sync two
// - Result high bits high, low bits low
// - Low byte read locks until high read
module dac_ctrl (
    // Clock, reset, clock enable
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       ce,
    // Avalon-MM slave
    input  wire logic [3:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [7:0] avs_writedata,
    output logic      [7:0] avs_readdata,
    output logic            avs_waitrequest,
    // Power stage sync inputs (asynchronous)
    input  wire logic       power_stage_sync_r,
    input  wire logic       power_stage_sync_two,
    // Amplifier analog status and result, other channel request
    input  wire logic       amp_out_change,
    input  wire logic [9:0] adc_result,
    input  wire logic       other_conv_req,
    // Analog switch controls, sample strobes, conversion status and grant
    output logic            amp_on,
    output logic            amp_shunt_sw,
    output logic            amp_gnd_sw,
    output logic            amp_neg_pin_sw,
    output logic      [1:0] amp_gain,
    output logic            amp_sample,
    output logic            adc_sample,
    output logic            conv_busy,
    output logic            conv_done,
    output logic            other_conv_grant
);
    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [7:0]          amplifier_control_status;
    logic                conversion_start_bit;
    logic                auto_trig;
    logic                mux_amp;
    logic [9:0]          result;
    logic                res_lock;
    logic                en_pend_off;
    logic                ack;
    dac_pkg::dac_state_e state;
    logic [4:0]          cnt;
    logic [4:0]          conv_len;
    logic [3:0]          div_cnt;
    logic                ps_r_lvl;
    logic                ps_two_lvl;
    logic                sync_lvl;
    logic                sync_prev;
    logic                trig_seen;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire       acc       = (avs_read | avs_write) & ~ack;
    wire       wr_ctrl   = ack & avs_write & // Commit on answer edge
                           (avs_address == dac_pkg::ADDR_CTRL);
    wire       wr_conv   = ack & avs_write &
                           (avs_address == dac_pkg::ADDR_CONV);
    wire       rd_lo     = acc & avs_read &
                           (avs_address == dac_pkg::ADDR_RES_LO);
    wire       rd_hi     = acc & avs_read &
                           (avs_address == dac_pkg::ADDR_RES_HI);
    wire [1:0] sync_sel  = amplifier_control_status[dac_pkg::CTRL_SYNC_HI:
                                                     dac_pkg::CTRL_SYNC_LO];
    wire       ctrl_en   = amplifier_control_status[dac_pkg::CTRL_EN_BIT];
    wire       ctrl_sh   = amplifier_control_status[dac_pkg::CTRL_SHUNT_BIT];
    wire       ctrl_gnd  = amplifier_control_status[dac_pkg::CTRL_GND_BIT];
    wire       div8_lvl  = (div_cnt >= dac_pkg::DIV8_HALF);
    wire       in_conv   = (state == dac_pkg::DAC_CONV);
    wire       in_sample = in_conv & (cnt < dac_pkg::SAMPLE_END);

    // Source mux; reserved code gives a constant level
    wire next_sync_lvl = (sync_sel == dac_pkg::SYNC_DIV8)   ? div8_lvl :
                         (sync_sel == dac_pkg::SYNC_PS_R)   ? ps_r_lvl :
                         (sync_sel == dac_pkg::SYNC_PS_TWO) ? ps_two_lvl :
                                                              1'b0;
    // Amplifier captures on the falling edge of its sync
    wire sync_fall  = sync_prev & ~sync_lvl & ctrl_en &
                      (sync_sel != dac_pkg::SYNC_RSVD);
    wire start_req  = wr_conv & avs_writedata[dac_pkg::CONV_START_BIT];
    wire amp_ch_sel = wr_conv ? avs_writedata[dac_pkg::CONV_MUXAMP_BIT]
                              : mux_amp;
    // Manual start is immediate when amplified channel is selected
    wire go_manual  = (state == dac_pkg::DAC_IDLE) & conversion_start_bit &
                      mux_amp & ~auto_trig & ctrl_en;
    // Auto mode waits for the next sync event after a trigger
    wire go_auto    = (state == dac_pkg::DAC_WAIT) & sync_fall & trig_seen;
    // Length depends on divided clock phase at start
    wire [4:0] next_len = (sync_sel == dac_pkg::SYNC_DIV8 && div8_lvl) ?
                          dac_pkg::CONV_LEN_HIGH : dac_pkg::CONV_LEN_LOW;
    wire conv_end   = in_conv & (cnt == conv_len - 5'h01) & ~amp_out_change;
    // Abort when output moves during sample
    wire abort      = in_sample & amp_out_change;

    // Read mux
    wire [7:0] rd_mux =
        (avs_address == dac_pkg::ADDR_CTRL)   ? amplifier_control_status :
        (avs_address == dac_pkg::ADDR_CONV)   ?
            {5'h00, mux_amp, auto_trig, conversion_start_bit} :
        (avs_address == dac_pkg::ADDR_RES_LO) ? result[7:0] :
        (avs_address == dac_pkg::ADDR_RES_HI) ? {6'h00, result[9:8]} :
        (avs_address == dac_pkg::ADDR_STATUS) ?
            {5'h00, res_lock, en_pend_off, in_conv} : 8'h00;

    // ---------------------------------------------------------------
    // Sync inputs and dividers
    // ---------------------------------------------------------------
    dac_sync3 u_sync_r (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .din     (power_stage_sync_r),
        .dout    (ps_r_lvl)
    );

    dac_sync3 u_sync_two (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .din     (power_stage_sync_two),
        .dout    (ps_two_lvl)
    );

    // Divide-by-eight phase counter, free running
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_cnt   <= 4'h0;
            sync_lvl  <= 1'b0;
            sync_prev <= 1'b0;
        end else if (ce) begin
            div_cnt   <= (div_cnt == dac_pkg::DIV8_LAST) ? 4'h0
                                                         : div_cnt + 4'h1;
            sync_lvl  <= next_sync_lvl;
            sync_prev <= sync_lvl;
        end
    end

    // ---------------------------------------------------------------
    // Bus slave: one wait cycle, then answer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack          <= 1'b0;
            avs_readdata <= 8'h00;
        end else if (ce) begin
            ack <= acc;
            if (acc) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Waitrequest drops in the cycle after the request is seen
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            avs_waitrequest <= ~acc;
        end
    end

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            amplifier_control_status <= dac_pkg::CTRL_RESET;
            en_pend_off              <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                // A disable during conversion is deferred
                amplifier_control_status <=
                    (avs_writedata & dac_pkg::CTRL_WMASK) |
                    {in_conv & ~avs_writedata[dac_pkg::CTRL_EN_BIT],
                     7'h00};
                en_pend_off <= in_conv &
                               ~avs_writedata[dac_pkg::CTRL_EN_BIT];
            end else if (en_pend_off && !in_conv) begin
                amplifier_control_status[dac_pkg::CTRL_EN_BIT] <= 1'b0;
                en_pend_off <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Conversion control register and trigger latch
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conversion_start_bit <= 1'b0;
            auto_trig            <= 1'b0;
            mux_amp              <= 1'b0;
            trig_seen            <= 1'b0;
        end else if (ce) begin
            if (wr_conv) begin
                auto_trig <= avs_writedata[dac_pkg::CONV_AUTO_BIT];
                mux_amp   <= avs_writedata[dac_pkg::CONV_MUXAMP_BIT];
            end
            // Start bit self-clears at conversion end; a new set wins
            if (start_req) begin
                conversion_start_bit <= 1'b1;
            end else if (conv_end) begin
                conversion_start_bit <= 1'b0;
            end
            // Trigger event latched until it is consumed
            if (start_req && avs_writedata[dac_pkg::CONV_AUTO_BIT]) begin
                trig_seen <= 1'b1;
            end else if (go_auto) begin
                trig_seen <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state    <= dac_pkg::DAC_IDLE;
            cnt      <= 5'h00;
            conv_len <= dac_pkg::CONV_LEN_LOW;
        end else if (ce) begin
            unique case (state)
                dac_pkg::DAC_IDLE: begin
                    if (go_manual) begin
                        state    <= dac_pkg::DAC_CONV;
                        cnt      <= 5'h00;
                        conv_len <= next_len;
                    end else if (trig_seen && amp_ch_sel && ctrl_en) begin
                        state <= dac_pkg::DAC_WAIT;
                    end
                end
                dac_pkg::DAC_WAIT: begin
                    if (go_auto) begin
                        state    <= dac_pkg::DAC_CONV;
                        cnt      <= 5'h00;
                        conv_len <= dac_pkg::CONV_LEN_LOW;
                    end
                end
                dac_pkg::DAC_CONV: begin
                    if (abort) begin
                        cnt <= 5'h00; // Restart on stable output
                    end else if (conv_end) begin
                        state <= dac_pkg::DAC_IDLE;
                    end else if (!amp_out_change) begin
                        cnt <= cnt + 5'h01;
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Result registers with read lock
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result   <= dac_pkg::RESULT_RESET;
            res_lock <= 1'b0;
        end else if (ce) begin
            // Low read locks, high read releases
            if (rd_lo) begin
                res_lock <= 1'b1;
            end else if (rd_hi) begin
                res_lock <= 1'b0;
            end
            if (conv_end && !res_lock && !rd_lo) begin
                result <= adc_result; // High/low byte split
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            amp_on           <= 1'b0;
            amp_shunt_sw     <= 1'b0;
            amp_gnd_sw       <= 1'b0;
            amp_neg_pin_sw   <= 1'b1;
            amp_gain         <= 2'h0;
            amp_sample       <= 1'b0;
            adc_sample       <= 1'b0;
            conv_busy        <= 1'b0;
            conv_done        <= 1'b0;
            other_conv_grant <= 1'b0;
        end else if (ce) begin
            amp_on         <= ctrl_en;
            amp_shunt_sw   <= ctrl_sh;
            amp_gnd_sw     <= ctrl_gnd & ~ctrl_sh;
            amp_neg_pin_sw <= ~ctrl_gnd;
            amp_gain       <= amplifier_control_status[dac_pkg::CTRL_GAIN_HI:
                              dac_pkg::CTRL_GAIN_LO];
            amp_sample     <= sync_fall;
            adc_sample     <= in_sample;
            conv_busy      <= ~(state == dac_pkg::DAC_IDLE);
            conv_done      <= conv_end;
            // Other channels refused while amplified path busy
            other_conv_grant <= other_conv_req &
                                (state == dac_pkg::DAC_IDLE) & ~go_manual;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_refuse_busy: assert property (@(posedge clk_sys) disable iff (rst)
        ce && in_conv |=> !other_conv_grant)
        else $error("other channel granted during conversion");

    a_gnd_shunt: assert property (@(posedge clk_sys) disable iff (rst)
        ce && ctrl_sh |=> !amp_gnd_sw)
        else $error("ground switch closed during shunt");

    a_neg_pin: assert property (@(posedge clk_sys) disable iff (rst)
        ce && ctrl_gnd |=> !amp_neg_pin_sw)
        else $error("negative pin still connected");

    a_rsvd_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        sync_sel == dac_pkg::SYNC_RSVD && $past(sync_sel) ==
        dac_pkg::SYNC_RSVD |-> !sync_fall)
        else $error("sync event on reserved code");

    a_lock_hold: assert property (@(posedge clk_sys) disable iff (rst)
        ce && res_lock && !rd_hi |=> $stable(result))
        else $error("result changed while locked");

    a_en_defer: assert property (@(posedge clk_sys) disable iff (rst)
        in_conv && en_pend_off && !wr_ctrl |-> ctrl_en)
        else $error("enable dropped mid conversion");

    a_len_range: assert property (@(posedge clk_sys) disable iff (rst)
        in_conv |-> conv_len == dac_pkg::CONV_LEN_LOW ||
                    conv_len == dac_pkg::CONV_LEN_HIGH)
        else $error("bad conversion length");

    a_abort_restart: assert property (@(posedge clk_sys) disable iff (rst)
        ce && abort |=> cnt == 5'h00 && in_conv)
        else $error("abort did not restart");

    a_manual_go: assert property (@(posedge clk_sys) disable iff (rst)
        ce && go_manual |=> in_conv)
        else $error("manual start not taken");

    c_manual: cover property (@(posedge clk_sys) go_manual ##[1:20] conv_end);
    c_auto:   cover property (@(posedge clk_sys) go_auto);
    c_abort:  cover property (@(posedge clk_sys) abort);
endmodule : dac_ctrl

// file: hdl/dac_pkg.sv
package dac_pkg;
    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL     = 4'h0; // Amplifier control
    localparam logic [3:0] ADDR_CONV     = 4'h1; // Conversion control
    localparam logic [3:0] ADDR_RES_LO   = 4'h2; // Result low byte
    localparam logic [3:0] ADDR_RES_HI   = 4'h3; // Result high byte
    localparam logic [3:0] ADDR_STATUS   = 4'h4; // Block state

    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] CTRL_WMASK    = 8'hFB; // Bit 2 reserved

    // Control field positions
    localparam int CTRL_EN_BIT           = 7;
    localparam int CTRL_SHUNT_BIT        = 6;
    localparam int CTRL_GAIN_HI          = 5;
    localparam int CTRL_GAIN_LO          = 4;
    localparam int CTRL_GND_BIT          = 3;
    localparam int CTRL_SYNC_HI          = 1;
    localparam int CTRL_SYNC_LO          = 0;

    // Conversion control fields
    localparam int CONV_START_BIT        = 0;
    localparam int CONV_AUTO_BIT         = 1;
    localparam int CONV_MUXAMP_BIT       = 2;

    // Sync selection codes
    localparam logic [1:0] SYNC_DIV8     = 2'h0;
    localparam logic [1:0] SYNC_PS_R     = 2'h1;
    localparam logic [1:0] SYNC_RSVD     = 2'h2;
    localparam logic [1:0] SYNC_PS_TWO   = 2'h3;

    // Timing in ADC clock cycles
    localparam logic [3:0] DIV8_LAST     = 4'h7;
    localparam logic [3:0] DIV8_HALF     = 4'h4;
    localparam logic [4:0] CONV_LEN_LOW  = 5'h0D; // 13 cycles
    localparam logic [4:0] CONV_LEN_HIGH = 5'h0E; // 14 cycles
    localparam logic [4:0] SAMPLE_END    = 5'h02; // Sample window length
    localparam logic [9:0] RESULT_RESET  = 10'h000;

    typedef enum logic [2:0] {
        DAC_IDLE = 3'b001,
        DAC_WAIT = 3'b010,
        DAC_CONV = 3'b100
    } dac_state_e;
endpackage : dac_pkg

// file: hdl/dac_sync3.sv
`timescale 1ns/1ns
// Three-stage input synchroniser with agreement filter
module dac_sync3 (
    // Clock and control
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic ce,
    // Asynchronous input and filtered level
    input  wire logic din,
    output logic      dout
);
    logic s1;
    logic s2;
    logic s3;

    // Stage one is read only by stage two
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                dout <= s3;
            end
        end
    end
endmodule : dac_sync3
